// ### shared/rsr_pkg.sv
// Constants and types for the status-reporting and remote-settings bank.
// Assumes a command parser outside that presents one decoded command per cycle.
package rsr_pkg;

	// Standard event flag positions
	localparam int RSR_SE_OPC = 0;
	localparam int RSR_SE_RQC = 1;
	localparam int RSR_SE_QYE = 2;
	localparam int RSR_SE_DDE = 3;
	localparam int RSR_SE_EXE = 4;
	localparam int RSR_SE_CME = 5;
	localparam int RSR_SE_URQ = 6;
	localparam int RSR_SE_PON = 7;

	// Status byte positions
	localparam int RSR_SB_END = 0;
	localparam int RSR_SB_ERR = 1;
	localparam int RSR_SB_MAV = 4;
	localparam int RSR_SB_ESB = 5;
	localparam int RSR_SB_MSS = 6;
	localparam logic [7:0] RSR_SB_SUMMARY = 8'h33;

	// Completion and fault group positions
	localparam int RSR_CE_MEASURE = 0;
	localparam int RSR_CE_STATS = 1;
	localparam int RSR_FE_UNCAL = 0;
	localparam int RSR_FE_LIMIT = 1;

	// Reset values
	localparam logic [7:0] RSR_SE_RESET = 8'h80;
	localparam logic [7:0] RSR_MASK_RESET = 8'h00;
	localparam logic [2:0] RSR_AUX_RESET = 3'h0;
	localparam logic [2:0] RSR_ATTEN_RESET = 3'h0;
	localparam logic [15:0] RSR_FREQ_RESET_MHZ = 16'h0258;

	// Attenuator and auxiliary selector limits
	localparam logic [2:0] RSR_ATTEN_CODE_MAX = 3'h7;
	localparam logic [5:0] RSR_ATTEN_MAX_DB = 6'h2a;
	localparam logic [5:0] RSR_ATTEN_STEP_DB = 6'h06;
	localparam logic [7:0] RSR_AUX_CODE_MAX = 8'h06;

	// Manual frequency range and resolution
	localparam logic [36:0] RSR_HZ_PER_MHZ = 37'h00000f4240;
	localparam logic [36:0] RSR_HALF_MHZ_HZ = 37'h000007a120;
	localparam logic [35:0] RSR_FREQ_MIN_HZ = 36'h023c34600;
	localparam logic [35:0] RSR_FREQ_MAX_HZ = 36'h9502f9000;

	typedef enum logic [4:0] {
		RSR_CMD_NOP, RSR_CMD_SET_EVENT_MASK, RSR_CMD_SET_SERVICE_MASK,
		RSR_CMD_SET_COMPLETION_MASK, RSR_CMD_SET_FAULT_MASK, RSR_CMD_OPC, RSR_CMD_CLS,
		RSR_CMD_SET_ACQUIRE, RSR_CMD_SET_ATTEN, RSR_CMD_SET_AUX, RSR_CMD_SET_FREQ,
		RSR_CMD_READ_EVENTS, RSR_CMD_READ_EVENT_MASK, RSR_CMD_READ_STATUS,
		RSR_CMD_READ_SERVICE_MASK, RSR_CMD_READ_COMPLETION, RSR_CMD_READ_COMPLETION_MASK,
		RSR_CMD_READ_FAULT, RSR_CMD_READ_FAULT_MASK, RSR_CMD_READ_ACQUIRE,
		RSR_CMD_READ_ATTEN, RSR_CMD_READ_AUX
	} rsr_cmd_type;

	typedef struct packed {
		logic [7:0] event_flags;
		logic [7:0] event_mask;
		logic [7:0] service_mask;
		logic [7:0] completion_flags;
		logic [7:0] completion_mask;
		logic [7:0] fault_flags;
		logic [7:0] fault_mask;
		logic [7:0] status_byte;
		logic opc_armed;
		logic acq_manual;
		logic acq_use_measured;
		logic [2:0] atten_code;
		logic [5:0] atten_db;
		logic [2:0] aux_sel;
		logic aux_out;
		logic [15:0] freq_mhz;
		logic rsp_valid;
		logic [7:0] rsp_data;
		logic srq;
	} rsr_state_type;

	localparam rsr_state_type RSR_STATE_RESET = '{
		event_flags: RSR_SE_RESET, event_mask: RSR_MASK_RESET, service_mask: RSR_MASK_RESET,
		completion_flags: 8'h00, completion_mask: RSR_MASK_RESET, fault_flags: 8'h00,
		fault_mask: RSR_MASK_RESET, status_byte: 8'h00, opc_armed: 1'b0, acq_manual: 1'b0,
		acq_use_measured: 1'b0, atten_code: RSR_ATTEN_RESET, atten_db: RSR_ATTEN_MAX_DB,
		aux_sel: RSR_AUX_RESET, aux_out: 1'b1, freq_mhz: RSR_FREQ_RESET_MHZ,
		rsp_valid: 1'b0, rsp_data: 8'h00, srq: 1'b0};

endpackage

// ### design/rsr_status_bank.sv
// Status byte, event register groups and remote settings of the counter.
// Assumes commands arrive already parsed, one per cycle, and that all
// event inputs are one-cycle pulses or levels from logic on clk.
//
// Notes on behaviour
// - Power-on flag set by every power-up.
// - User, device and control flags read zero.
// - Parse, header or trigger faults set command error.
// - Range or conflict faults set execution error.
// - Empty-queue read or lost data: query error.
// - Operation complete once pending work finishes.
// - Event summary bit from masked standard flags.
// - Message-available bit while queue holds data.
// - Fault summary bit from masked fault flags.
// - Completion summary bit from masked completion flags.
// - Master summary when any summary condition present.
// - Service request only for enabled summaries.
// - Unassigned status and group bits read zero.
// - Measurement end sets measurement-done flag.
// - Statistics end sets statistics-done flag.
// - Uncalibrated result sets uncalibrated flag.
// - Enabled limit check failing sets limit-fail.
// - Acquire auto or manual, preset or measured.
// - Manual frequency kept in whole megahertz.
// - Auxiliary source codes 0..6, off and pass/fail.
// - Auxiliary end, restart, gate and acquire sources.
// - Operation complete is standard flag bit 0.
// - Group masks take 0..255, reset zero.
`timescale 1ns/1ps

module rsr_status_bank (
	input wire logic clk,
	input wire logic reset,
	input wire logic cmd_valid,
	input wire rsr_pkg::rsr_cmd_type cmd_op,
	input wire logic [7:0] cmd_arg,
	input wire logic cmd_sub,
	input wire logic [35:0] cmd_freq_hz,
	input wire logic parse_error,
	input wire logic bad_header,
	input wire logic trigger_in_message,
	input wire logic param_range_error,
	input wire logic setting_conflict,
	input wire logic query_empty,
	input wire logic queue_lost,
	input wire logic queue_nonempty,
	input wire logic ops_pending,
	input wire logic measure_done,
	input wire logic stats_done,
	input wire logic result_valid,
	input wire logic result_uncal,
	input wire logic limit_enable,
	input wire logic judgment_fail,
	input wire logic judgment_in_range,
	input wire logic level_detect,
	input wire logic gate_open,
	input wire logic restart_pulse,
	input wire logic acquiring,
	input wire logic [15:0] measured_freq_mhz,
	output logic rsp_valid,
	output logic [7:0] rsp_data,
	output logic [7:0] status_byte,
	output logic service_request,
	output logic aux_out,
	output logic [5:0] atten_db,
	output logic acq_manual,
	output logic acq_use_measured,
	output logic [15:0] manual_freq_mhz
);

	rsr_pkg::rsr_state_type st_q;
	rsr_pkg::rsr_state_type st_d;
	logic [7:0] event_set;
	logic [7:0] completion_set;
	logic [7:0] fault_set;
	logic read_events;
	logic read_completion;
	logic read_fault;
	logic clear_all;
	logic [7:0] summary;
	logic [36:0] hz_rounded;
	logic [7:0] aux_code;

	default clocking cb @(posedge clk);
	endclocking
	default disable iff (reset);

	function automatic logic [5:0] atten_of(input logic [2:0] code);
		logic [5:0] step;
		step = {3'h0, code};
		return 6'(rsr_pkg::RSR_ATTEN_MAX_DB - 6'(rsr_pkg::RSR_ATTEN_STEP_DB * step));
	endfunction

	function automatic logic is_cmd(input logic v, input rsr_pkg::rsr_cmd_type op,
			input rsr_pkg::rsr_cmd_type want);
		return v && (op == want);
	endfunction

	always_comb begin
		st_d = st_q;
		st_d.rsp_valid = 1'b0;
		st_d.rsp_data = 8'h00;
		event_set = 8'h00;
		completion_set = 8'h00;
		fault_set = 8'h00;
		hz_rounded = {1'b0, cmd_freq_hz} + rsr_pkg::RSR_HALF_MHZ_HZ;
		aux_code = cmd_arg;
		read_events = is_cmd(cmd_valid, cmd_op, rsr_pkg::RSR_CMD_READ_EVENTS);
		read_completion = is_cmd(cmd_valid, cmd_op, rsr_pkg::RSR_CMD_READ_COMPLETION);
		read_fault = is_cmd(cmd_valid, cmd_op, rsr_pkg::RSR_CMD_READ_FAULT);
		clear_all = is_cmd(cmd_valid, cmd_op, rsr_pkg::RSR_CMD_CLS);

		// Standard event sources
		event_set[rsr_pkg::RSR_SE_CME] = parse_error | bad_header | trigger_in_message;
		event_set[rsr_pkg::RSR_SE_EXE] = param_range_error | setting_conflict;
		event_set[rsr_pkg::RSR_SE_QYE] = query_empty | queue_lost;
		if (st_q.opc_armed && !ops_pending) begin
			event_set[rsr_pkg::RSR_SE_OPC] = 1'b1;
			st_d.opc_armed = 1'b0;
		end

		// Group event sources
		completion_set[rsr_pkg::RSR_CE_MEASURE] = measure_done;
		completion_set[rsr_pkg::RSR_CE_STATS] = stats_done;
		fault_set[rsr_pkg::RSR_FE_UNCAL] = result_valid & result_uncal;
		fault_set[rsr_pkg::RSR_FE_LIMIT] = result_valid & limit_enable & judgment_fail;

		if (cmd_valid) begin
			unique case (cmd_op)
				rsr_pkg::RSR_CMD_SET_EVENT_MASK: st_d.event_mask = cmd_arg;
				rsr_pkg::RSR_CMD_SET_SERVICE_MASK: st_d.service_mask = cmd_arg;
				rsr_pkg::RSR_CMD_SET_COMPLETION_MASK: st_d.completion_mask = cmd_arg;
				rsr_pkg::RSR_CMD_SET_FAULT_MASK: st_d.fault_mask = cmd_arg;
				rsr_pkg::RSR_CMD_OPC: st_d.opc_armed = 1'b1;
				rsr_pkg::RSR_CMD_CLS: st_d.opc_armed = 1'b0;
				rsr_pkg::RSR_CMD_SET_ACQUIRE: begin
					// Manual with measured source copies the last result over the preset
					st_d.acq_manual = cmd_arg[0];
					st_d.acq_use_measured = cmd_arg[0] & cmd_sub;
					if (cmd_arg[0] && cmd_sub) begin
						st_d.freq_mhz = measured_freq_mhz;
					end
					if (cmd_arg > 8'h01) begin
						event_set[rsr_pkg::RSR_SE_EXE] = 1'b1;
						st_d.acq_manual = st_q.acq_manual;
						st_d.acq_use_measured = st_q.acq_use_measured;
						st_d.freq_mhz = st_q.freq_mhz;
					end
				end
				rsr_pkg::RSR_CMD_SET_ATTEN: begin
					// Codes above the last step saturate at through
					if (cmd_arg >= 8'(rsr_pkg::RSR_ATTEN_CODE_MAX)) begin
						st_d.atten_code = rsr_pkg::RSR_ATTEN_CODE_MAX;
					end else begin
						st_d.atten_code = cmd_arg[2:0];
					end
				end
				rsr_pkg::RSR_CMD_SET_AUX: begin
					if (aux_code > rsr_pkg::RSR_AUX_CODE_MAX) begin
						event_set[rsr_pkg::RSR_SE_EXE] = 1'b1;
					end else begin
						st_d.aux_sel = aux_code[2:0];
					end
				end
				rsr_pkg::RSR_CMD_SET_FREQ: begin
					if (cmd_freq_hz < rsr_pkg::RSR_FREQ_MIN_HZ || cmd_freq_hz > rsr_pkg::RSR_FREQ_MAX_HZ) begin
						event_set[rsr_pkg::RSR_SE_EXE] = 1'b1;
					end else begin
						st_d.freq_mhz = 16'(hz_rounded / rsr_pkg::RSR_HZ_PER_MHZ);
					end
				end
				rsr_pkg::RSR_CMD_READ_EVENTS: st_d.rsp_data = st_q.event_flags;
				rsr_pkg::RSR_CMD_READ_EVENT_MASK: st_d.rsp_data = st_q.event_mask;
				rsr_pkg::RSR_CMD_READ_STATUS: st_d.rsp_data = st_q.status_byte;
				rsr_pkg::RSR_CMD_READ_SERVICE_MASK: st_d.rsp_data = st_q.service_mask;
				rsr_pkg::RSR_CMD_READ_COMPLETION: st_d.rsp_data = st_q.completion_flags;
				rsr_pkg::RSR_CMD_READ_COMPLETION_MASK: st_d.rsp_data = st_q.completion_mask;
				rsr_pkg::RSR_CMD_READ_FAULT: st_d.rsp_data = st_q.fault_flags;
				rsr_pkg::RSR_CMD_READ_FAULT_MASK: st_d.rsp_data = st_q.fault_mask;
				rsr_pkg::RSR_CMD_READ_ACQUIRE: st_d.rsp_data = {7'h00, st_q.acq_manual};
				rsr_pkg::RSR_CMD_READ_ATTEN: st_d.rsp_data = {5'h00, st_q.atten_code};
				rsr_pkg::RSR_CMD_READ_AUX: st_d.rsp_data = {5'h00, st_q.aux_sel};
				default: st_d.rsp_data = 8'h00;
			endcase
			st_d.rsp_valid = cmd_op >= rsr_pkg::RSR_CMD_READ_EVENTS;
		end

		// Read or clear empties a group, but an event in the same cycle survives
		st_d.event_flags = ((read_events || clear_all) ? 8'h00 : st_q.event_flags) | event_set;
		st_d.completion_flags = ((read_completion || clear_all) ? 8'h00 : st_q.completion_flags)
			| completion_set;
		st_d.fault_flags = ((read_fault || clear_all) ? 8'h00 : st_q.fault_flags) | fault_set;
		st_d.event_flags[rsr_pkg::RSR_SE_URQ] = 1'b0;
		st_d.event_flags[rsr_pkg::RSR_SE_DDE] = 1'b0;
		st_d.event_flags[rsr_pkg::RSR_SE_RQC] = 1'b0;

		// Summaries follow next-state flags so they never lag the flags
		summary = 8'h00;
		summary[rsr_pkg::RSR_SB_ESB] = |(st_d.event_flags & st_d.event_mask);
		summary[rsr_pkg::RSR_SB_MAV] = queue_nonempty;
		summary[rsr_pkg::RSR_SB_ERR] = |(st_d.fault_flags & st_d.fault_mask);
		summary[rsr_pkg::RSR_SB_END] = |(st_d.completion_flags & st_d.completion_mask);
		st_d.status_byte = summary;
		st_d.status_byte[rsr_pkg::RSR_SB_MSS] = |summary;
		st_d.srq = |(summary & st_d.service_mask & rsr_pkg::RSR_SB_SUMMARY);

		st_d.atten_db = atten_of(st_d.atten_code);

		// Auxiliary connector source
		unique case (st_q.aux_sel)
			3'h1: st_d.aux_out = judgment_in_range;
			3'h2: st_d.aux_out = ~measure_done;
			3'h3: st_d.aux_out = level_detect;
			3'h4: st_d.aux_out = gate_open;
			3'h5: st_d.aux_out = ~restart_pulse;
			3'h6: st_d.aux_out = ~acquiring;
			// Off idles high; with limits on it also stays high
			default: st_d.aux_out = 1'b1;
		endcase
	end

	// Reset loads the power-on flag, one flag per power-up
	always_ff @(posedge clk or posedge reset) begin
		if (reset) begin
			st_q <= rsr_pkg::RSR_STATE_RESET;
		end else begin
			st_q <= st_d;
		end
	end

	assign rsp_valid = st_q.rsp_valid;
	assign rsp_data = st_q.rsp_data;
	assign status_byte = st_q.status_byte;
	assign service_request = st_q.srq;
	assign aux_out = st_q.aux_out;
	assign atten_db = st_q.atten_db;
	assign acq_manual = st_q.acq_manual;
	assign acq_use_measured = st_q.acq_use_measured;
	assign manual_freq_mhz = st_q.freq_mhz;

	unused_event_zero_a: assert property (
		st_q.event_flags[rsr_pkg::RSR_SE_URQ] == 1'b0 && st_q.event_flags[rsr_pkg::RSR_SE_DDE] == 1'b0
		&& st_q.event_flags[rsr_pkg::RSR_SE_RQC] == 1'b0)
		else $error("unused standard flag set");

	command_error_set_a: assert property (
		(parse_error || bad_header || trigger_in_message) |=> st_q.event_flags[rsr_pkg::RSR_SE_CME])
		else $error("command error flag not set");

	query_error_set_a: assert property (
		(query_empty || queue_lost) |=> st_q.event_flags[rsr_pkg::RSR_SE_QYE])
		else $error("query error flag not set");

	opc_finish_a: assert property (
		(st_q.opc_armed && !ops_pending && !(cmd_valid && cmd_op == rsr_pkg::RSR_CMD_OPC))
		|=> (st_q.event_flags[rsr_pkg::RSR_SE_OPC] && !st_q.opc_armed))
		else $error("operation complete not reported");

	opc_wait_a: assert property (
		(st_q.opc_armed && ops_pending && !st_q.event_flags[rsr_pkg::RSR_SE_OPC] && !clear_all)
		|=> !st_q.event_flags[rsr_pkg::RSR_SE_OPC])
		else $error("operation complete set early");

	event_summary_a: assert property (
		st_q.status_byte[rsr_pkg::RSR_SB_ESB] == |(st_q.event_flags & st_q.event_mask))
		else $error("event summary bit wrong");

	mav_follow_a: assert property (
		queue_nonempty |=> st_q.status_byte[rsr_pkg::RSR_SB_MAV] && st_q.status_byte[rsr_pkg::RSR_SB_MSS])
		else $error("message available not shown");

	fault_summary_a: assert property (
		st_q.status_byte[rsr_pkg::RSR_SB_ERR] == |(st_q.fault_flags & st_q.fault_mask))
		else $error("fault summary bit wrong");

	service_gate_a: assert property (
		st_q.srq == |(st_q.status_byte & st_q.service_mask & rsr_pkg::RSR_SB_SUMMARY))
		else $error("service request not gated by mask");

	unassigned_zero_a: assert property (
		(st_q.status_byte & 8'h8c) == 8'h00 && st_q.completion_flags[7:2] == 6'h00
		&& st_q.fault_flags[7:2] == 6'h00)
		else $error("unassigned bit set");

	measure_flag_a: assert property (
		measure_done |=> st_q.completion_flags[rsr_pkg::RSR_CE_MEASURE])
		else $error("measurement flag not set");

	limit_flag_a: assert property (
		(result_valid && limit_enable && judgment_fail) |=> st_q.fault_flags[rsr_pkg::RSR_FE_LIMIT])
		else $error("limit fail flag not set");

	atten_decode_a: assert property (
		(cmd_valid && cmd_op == rsr_pkg::RSR_CMD_SET_ATTEN && cmd_arg >= 8'h07) |=> st_q.atten_db == 6'h00)
		else $error("attenuator saturation wrong");

	read_clear_a: assert property (
		(cmd_valid && cmd_op == rsr_pkg::RSR_CMD_READ_COMPLETION && !measure_done && !stats_done)
		|=> (st_q.completion_flags == 8'h00 && st_q.rsp_valid && st_q.rsp_data == $past(st_q.completion_flags)))
		else $error("completion read did not clear");

endmodule

// ### sim/rsr_host_model.sv
// Controller model driving the command port of the status bank.
// Assumes one clk; requests change 1 ns after a rising edge.
`timescale 1ns/1ps

module rsr_host_model (
	input wire logic clk,
	input wire logic rsp_valid,
	input wire logic [7:0] rsp_data,
	output rsr_pkg::rsr_cmd_type cmd_op,
	output logic cmd_valid,
	output logic [7:0] cmd_arg,
	output logic cmd_sub,
	output logic [35:0] cmd_freq_hz
);
	initial begin
		cmd_valid = 1'b0;
		cmd_op = rsr_pkg::RSR_CMD_NOP;
		cmd_arg = 8'h00;
		cmd_sub = 1'b0;
		cmd_freq_hz = 36'h000000000;
	end

	// Mask arguments are one byte, so only 0..255 can be sent
	task automatic send(input rsr_pkg::rsr_cmd_type op, input logic [7:0] arg, input logic sub,
		input logic [35:0] hz);
		@(posedge clk);
		#1;
		cmd_valid = 1'b1;
		cmd_op = op;
		cmd_arg = arg;
		cmd_sub = sub;
		cmd_freq_hz = hz;
		@(posedge clk);
		#1;
		cmd_valid = 1'b0;
		// Stale fields inverted so the bank cannot lean on them
		cmd_arg = ~arg;
		cmd_sub = ~sub;
		cmd_freq_hz = ~hz;
	endtask

	// Answer stands from the taking edge on; read 1 ns after it
	task automatic ask(input rsr_pkg::rsr_cmd_type op, output logic [7:0] d, output logic v);
		send(op, 8'h00, 1'b0, 36'h000000000);
		d = rsp_data;
		v = rsp_valid;
	endtask
endmodule

// ### sim/remote_status_reporting_tb_top.sv
// Self-checking bench for the status bank, driven by the controller model.
// Assumes the bank answers reads on the taking edge itself.
`timescale 1ns/1ps

module remote_status_reporting_tb_top;
	logic clk = 1'b0;
	logic reset = 1'b1;
	logic [19:0] ev = 20'h00000;
	logic [15:0] meas = 16'h1388;
	rsr_pkg::rsr_cmd_type cmd_op;
	logic cmd_valid, cmd_sub, rsp_valid, service_request, aux_out, acq_manual, acq_use_measured;
	logic [7:0] cmd_arg, rsp_data, status_byte;
	logic [35:0] cmd_freq_hz;
	logic [5:0] atten_db;
	logic [15:0] manual_freq_mhz;
	int mismatches = 0;
	int n_compared = 0;
	int bits[6] = '{16, 7, 17, 18, 11, 19};

	initial begin
		forever #20 clk = ~clk;
	end

	rsr_host_model u_host (.clk(clk), .rsp_valid(rsp_valid), .rsp_data(rsp_data), .cmd_op(cmd_op),
		.cmd_valid(cmd_valid), .cmd_arg(cmd_arg), .cmd_sub(cmd_sub), .cmd_freq_hz(cmd_freq_hz));

	rsr_status_bank u_dut (.clk(clk), .reset(reset), .cmd_valid(cmd_valid), .cmd_op(cmd_op),
		.cmd_arg(cmd_arg), .cmd_sub(cmd_sub), .cmd_freq_hz(cmd_freq_hz), .parse_error(ev[0]),
		.bad_header(ev[1]), .trigger_in_message(ev[2]), .param_range_error(ev[3]), .setting_conflict(ev[4]),
		.query_empty(ev[5]), .queue_lost(ev[6]), .measure_done(ev[7]), .stats_done(ev[8]),
		.result_valid(ev[9]), .result_uncal(ev[10]), .restart_pulse(ev[11]), .queue_nonempty(ev[12]),
		.ops_pending(ev[13]), .limit_enable(ev[14]), .judgment_fail(ev[15]), .judgment_in_range(ev[16]),
		.level_detect(ev[17]), .gate_open(ev[18]), .acquiring(ev[19]), .measured_freq_mhz(meas),
		.rsp_valid(rsp_valid), .rsp_data(rsp_data), .status_byte(status_byte),
		.service_request(service_request), .aux_out(aux_out), .atten_db(atten_db), .acq_manual(acq_manual),
		.acq_use_measured(acq_use_measured), .manual_freq_mhz(manual_freq_mhz));

	task automatic chk(input string nm, input logic [15:0] exp, input logic [15:0] got);
		n_compared++;
		if (got !== exp) begin
			mismatches++;
			$display("MISMATCH %s expected %h seen %h", nm, exp, got);
		end
	endtask

	task automatic cmd(input rsr_pkg::rsr_cmd_type op, input logic [7:0] arg);
		u_host.send(op, arg, 1'b0, 36'h000000000);
	endtask

	task automatic q(input rsr_pkg::rsr_cmd_type op, input logic [7:0] exp, input string nm);
		logic [7:0] d;
		logic v;
		u_host.ask(op, d, v);
		chk(nm, {8'h01, exp}, {7'h00, v, d});
	endtask

	task automatic lv(input int b, input logic v);
		@(posedge clk);
		#1;
		ev[b] = v;
	endtask

	// Extra idle cycle lets summaries settle before looking
	task automatic pulse(input logic [19:0] m);
		@(posedge clk);
		#1;
		ev = ev | m;
		@(posedge clk);
		#1;
		ev = ev & ~m;
		@(posedge clk);
		#1;
	endtask

	task automatic print_verdict;
		if (mismatches == 0 && n_compared > 0) begin
			$display("Finished cleanly");
		end else begin
			$display("Finished with errors");
		end
		$finish;
	endtask

	task automatic t_reset;
		chk("status", 16'h0000, {8'h00, status_byte});
		chk("outs", 16'h012a, {6'h00, service_request, aux_out, 2'h0, atten_db});
		chk("acq_freq", 16'h0258, manual_freq_mhz);
		chk("acq_mode", 16'h0000, {14'h0000, acq_manual, acq_use_measured});
		q(rsr_pkg::RSR_CMD_READ_EVENTS, 8'h80, "pon");
		q(rsr_pkg::RSR_CMD_READ_EVENTS, 8'h00, "cleared");
		q(rsr_pkg::RSR_CMD_READ_COMPLETION_MASK, 8'h00, "cmask");
		q(rsr_pkg::RSR_CMD_READ_FAULT_MASK, 8'h00, "fmask");
	endtask

	task automatic t_std_events;
		for (int i = 0; i < 7; i++) begin
			pulse(20'h00001 << i);
			q(rsr_pkg::RSR_CMD_READ_EVENTS, i < 3 ? 8'h20 : (i < 5 ? 8'h10 : 8'h04), "std");
		end
	endtask

	task automatic t_summary;
		cmd(rsr_pkg::RSR_CMD_SET_EVENT_MASK, 8'h20);
		pulse(20'h00008);
		chk("masked", 16'h0000, {8'h00, status_byte});
		pulse(20'h00001);
		chk("esb", 16'h0060, {7'h00, service_request, status_byte});
		cmd(rsr_pkg::RSR_CMD_SET_SERVICE_MASK, 8'h20);
		chk("srq", 16'h0001, {15'h0000, service_request});
		q(rsr_pkg::RSR_CMD_READ_STATUS, 8'h60, "stb");
		q(rsr_pkg::RSR_CMD_READ_EVENTS, 8'h30, "esr");
		chk("esb_off", 16'h0000, {7'h00, service_request, status_byte});
		lv(12, 1'b1);
		cmd(rsr_pkg::RSR_CMD_SET_SERVICE_MASK, 8'h10);
		chk("mav", 16'h0150, {7'h00, service_request, status_byte});
		lv(12, 1'b0);
		pulse(20'h00000);
		chk("mav_off", 16'h0000, {7'h00, service_request, status_byte});
	endtask

	task automatic t_groups;
		cmd(rsr_pkg::RSR_CMD_SET_COMPLETION_MASK, 8'h02);
		cmd(rsr_pkg::RSR_CMD_SET_SERVICE_MASK, 8'h01);
		pulse(20'h00080);
		chk("end_masked", 16'h0000, {7'h00, service_request, status_byte});
		pulse(20'h00100);
		chk("end_sum", 16'h0141, {7'h00, service_request, status_byte});
		q(rsr_pkg::RSR_CMD_READ_COMPLETION, 8'h03, "end_flags");
		cmd(rsr_pkg::RSR_CMD_SET_FAULT_MASK, 8'hff);
		pulse(20'h00600);
		chk("err_sum", 16'h0042, {8'h00, status_byte});
		q(rsr_pkg::RSR_CMD_READ_FAULT, 8'h01, "uncal");
		lv(15, 1'b1);
		pulse(20'h00200);
		q(rsr_pkg::RSR_CMD_READ_FAULT, 8'h00, "nolimit");
		lv(14, 1'b1);
		pulse(20'h00200);
		q(rsr_pkg::RSR_CMD_READ_FAULT, 8'h02, "limit");
		lv(14, 1'b0);
	endtask

	task automatic t_opc;
		lv(13, 1'b1);
		cmd(rsr_pkg::RSR_CMD_OPC, 8'h00);
		repeat (4) pulse(20'h00000);
		q(rsr_pkg::RSR_CMD_READ_EVENTS, 8'h00, "opc_wait");
		lv(13, 1'b0);
		pulse(20'h00000);
		cmd(rsr_pkg::RSR_CMD_SET_EVENT_MASK, 8'h01);
		cmd(rsr_pkg::RSR_CMD_SET_SERVICE_MASK, 8'h20);
		chk("opc_srq", 16'h0001, {15'h0000, service_request});
		q(rsr_pkg::RSR_CMD_READ_EVENTS, 8'h01, "opc");
	endtask

	task automatic t_settings;
		for (int c = 0; c < 10; c++) begin
			cmd(rsr_pkg::RSR_CMD_SET_ATTEN, c[7:0]);
			chk("atten", c > 6 ? 16'h0000 : 16'h002a - 16'(6 * c), {10'h000, atten_db});
		end
		u_host.send(rsr_pkg::RSR_CMD_SET_ACQUIRE, 8'h01, 1'b1, 36'h000000000);
		chk("acq_meas", meas, manual_freq_mhz);
		chk("acq_sel", 16'h0003, {14'h0000, acq_manual, acq_use_measured});
		u_host.send(rsr_pkg::RSR_CMD_SET_ACQUIRE, 8'h02, 1'b0, 36'h000000000);
		chk("acq_bad", 16'h0003, {14'h0000, acq_manual, acq_use_measured});
		u_host.send(rsr_pkg::RSR_CMD_SET_FREQ, 8'h00, 1'b0, 36'h04994f9a0);
		chk("f_up", 16'h04d3, manual_freq_mhz);
		u_host.send(rsr_pkg::RSR_CMD_SET_FREQ, 8'h00, 1'b0, 36'h04994f99f);
		chk("f_down", 16'h04d2, manual_freq_mhz);
		u_host.send(rsr_pkg::RSR_CMD_SET_FREQ, 8'h00, 1'b0, rsr_pkg::RSR_FREQ_MAX_HZ);
		chk("f_max", 16'h9c40, manual_freq_mhz);
		u_host.send(rsr_pkg::RSR_CMD_SET_FREQ, 8'h00, 1'b0, 36'h9503ed240);
		chk("f_over", 16'h9c40, manual_freq_mhz);
		q(rsr_pkg::RSR_CMD_READ_EVENTS, 8'h10, "exe");
	endtask

	task automatic t_aux;
		cmd(rsr_pkg::RSR_CMD_SET_AUX, 8'h00);
		chk("aux_off", 16'h0001, {15'h0000, aux_out});
		for (int c = 1; c < 7; c++) begin
			cmd(rsr_pkg::RSR_CMD_SET_AUX, c[7:0]);
			lv(bits[c - 1], 1'b1);
			lv(bits[c - 1], 1'b0);
			chk("aux_on", {15'h0000, c inside {1, 3, 4}}, {15'h0000, aux_out});
			pulse(20'h00000);
			chk("aux_idle", {15'h0000, !(c inside {1, 3, 4})}, {15'h0000, aux_out});
		end
		cmd(rsr_pkg::RSR_CMD_SET_AUX, 8'h07);
		q(rsr_pkg::RSR_CMD_READ_AUX, 8'h06, "aux_bad");
	endtask

	// Clear of all groups, then a second power-up in mid-run
	task automatic t_clear;
		pulse(20'h00681);
		cmd(rsr_pkg::RSR_CMD_CLS, 8'h00);
		chk("cls_stb", 16'h0000, {7'h00, service_request, status_byte});
		q(rsr_pkg::RSR_CMD_READ_EVENTS, 8'h00, "cls_std");
		q(rsr_pkg::RSR_CMD_READ_COMPLETION, 8'h00, "cls_end");
		q(rsr_pkg::RSR_CMD_READ_FAULT, 8'h00, "cls_err");
		q(rsr_pkg::RSR_CMD_READ_EVENT_MASK, 8'h01, "emask");
		q(rsr_pkg::RSR_CMD_READ_SERVICE_MASK, 8'h20, "smask");
		q(rsr_pkg::RSR_CMD_READ_ACQUIRE, 8'h01, "acq_rd");
		q(rsr_pkg::RSR_CMD_READ_ATTEN, 8'h07, "atten_rd");
		@(posedge clk);
		#1;
		reset = 1'b1;
		repeat (2) @(posedge clk);
		#1;
		reset = 1'b0;
		chk("rst_outs", 16'h012a, {6'h00, service_request, aux_out, 2'h0, atten_db});
		q(rsr_pkg::RSR_CMD_READ_EVENTS, 8'h80, "pon_again");
		q(rsr_pkg::RSR_CMD_READ_SERVICE_MASK, 8'h00, "smask_rst");
		q(rsr_pkg::RSR_CMD_READ_COMPLETION_MASK, 8'h00, "cmask_rst");
	endtask

	initial begin
		#2000000;
		mismatches++;
		print_verdict();
	end

	initial begin
		repeat (10) @(posedge clk);
		#1;
		reset = 1'b0;
		t_reset();
		t_std_events();
		t_summary();
		t_groups();
		t_opc();
		t_settings();
		t_aux();
		t_clear();
		print_verdict();
	end
endmodule
